// ---- jbu_jump_branch_unit.sv ----
// Jump and branch sequencer of a small 8-bit core: fetches opcodes,
// executes the jump group and hands every other opcode to the core.
// Assumes program memory answers a read within the machine cycle and
// that the flag and register pair inputs are stable during it.
//
// Behaviour
// - Opcode C3 loads operand into counter, 4-3-3
// - First operand byte low, second byte high
// - True absolute condition loads the operand
// - False condition skips three bytes, 4-3-3
// - Condition field selects one of eight tests on four flags
// - Opcode 18 always branches, 4-3-5
// - Branch reach -126 to +129 from opcode
// - Displacement added after counter passes both bytes
// - Opcode 38 branches on carry set
// - Opcode 30 branches on carry clear
// - Opcode 28 branches on zero set
// - Opcode 20 branches on zero clear
// - Taken 4-3-5, not taken 4-3
// - E9 loads pointer pair in four states
// - DD E9 loads first index pair, 4-4
// - No jump or branch alters any flag
`timescale 1ns/100ps
module jbu_jump_branch_unit
#(
  parameter int ADDR_W = 16
)
(
  input  wire logic              i_sys_clk,
  input  wire logic              i_reset,
  input  wire logic [7:0]        i_mem_data,
  input  wire logic [7:0]        i_flags,
  input  wire logic [15:0]       i_pointer_pair,
  input  wire logic [15:0]       i_first_index_pair,
  output logic      [ADDR_W-1:0] o_program_counter,
  output logic                   o_mem_rd,
  output logic                   o_m1,
  output logic                   o_instr_done,
  output logic                   o_branch_taken,
  output logic      [2:0]        o_last_mcycles,
  output logic      [4:0]        o_last_tstates,
  output logic                   o_foreign_op,
  output logic      [7:0]        o_foreign_opcode,
  output logic                   o_foreign_prefixed
);
  import jbu_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // One copy is registered; next_s is its combinational next value
  typedef struct packed {
    jbu_state_t        state;
    logic [2:0]        tcnt;
    logic [ADDR_W-1:0] pc;
    logic [7:0]        opcode;
    logic [7:0]        lo;
    logic [7:0]        disp;
    logic              prefix;
    logic [2:0]        mcnt;
    logic [4:0]        tsum;
    logic              mem_rd;
    logic              m1;
    logic              done;
    logic              taken;
    logic [2:0]        last_m;
    logic [4:0]        last_t;
    logic              foreign;
    logic [7:0]        foreign_op;
    logic              foreign_pfx;
  } jbu_regs_t;

  localparam jbu_regs_t REGS_RESET = '{
    state:       JBU_ST_FETCH,
    tcnt:        3'h0,
    pc:          ADDR_W'(JBU_PC_RESET),
    opcode:      8'h00,
    lo:          8'h00,
    disp:        8'h00,
    prefix:      1'b0,
    mcnt:        3'h0,
    tsum:        5'h00,
    mem_rd:      1'b1,
    m1:          1'b1,
    done:        1'b0,
    taken:       1'b0,
    last_m:      3'h0,
    last_t:      5'h00,
    foreign:     1'b0,
    foreign_op:  8'h00,
    foreign_pfx: 1'b0
  };

  jbu_regs_t         s;
  jbu_regs_t         next_s;
  logic [2:0]        cond_field;
  logic              cond_true;
  logic [ADDR_W-1:0] rel_target;
  logic              op_abs_cond;
  logic              op_rel;

  // ----------------------------------------------------------------
  // Condition and target helpers
  // ----------------------------------------------------------------
  // Absolute forms carry ccc in bits 5..3; relative forms map
  // 20/28/30/38 onto codes 000/001/010/011 through bits 4..3.
  always_comb
  begin
    if (s.opcode[7])
    begin
      cond_field = s.opcode[5:3];
    end
    else
    begin
      cond_field = {1'b0, s.opcode[4:3]};
    end
  end

  jbu_cond_eval u_cond (
    .i_condition_field (cond_field),
    .i_flags           (i_flags),
    .o_cond_true       (cond_true)
  );

  jbu_rel_target #(
    .ADDR_W (ADDR_W)
  ) u_target (
    .i_base   (s.pc),
    .i_disp   (s.disp),
    .o_target (rel_target)
  );

  // ----------------------------------------------------------------
  // Opcode classes of the byte on the bus
  // ----------------------------------------------------------------
  // Behind a DD prefix only the index jump is ours; all else is foreign.
  always_comb
  begin
    op_abs_cond = 1'b0;
    op_rel      = 1'b0;
    if (!s.prefix)
    begin
      op_abs_cond = (i_mem_data & JBU_ABS_COND_MASK) == JBU_ABS_COND_PAT;
      op_rel      = i_mem_data == JBU_OP_REL_ALWAYS ||
                    i_mem_data == JBU_OP_REL_NZ ||
                    i_mem_data == JBU_OP_REL_Z ||
                    i_mem_data == JBU_OP_REL_NC ||
                    i_mem_data == JBU_OP_REL_C;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [2:0]        tlen;
    logic              tlast;
    logic [ADDR_W-1:0] pc_inc;
    logic              finish;
    jbu_state_t        go;
    tlen   = JBU_T_FETCH;
    tlast  = 1'b0;
    pc_inc = s.pc + ADDR_W'(1);
    finish = 1'b0;
    go     = s.state;
    next_s = s;
    next_s.done    = 1'b0;
    next_s.taken   = 1'b0;
    next_s.foreign = 1'b0;

    case (s.state)
      JBU_ST_FETCH: tlen = JBU_T_FETCH;
      JBU_ST_LO:    tlen = JBU_T_READ;
      JBU_ST_HI:    tlen = JBU_T_READ;
      JBU_ST_DISP:  tlen = JBU_T_READ;
      JBU_ST_ADD:   tlen = JBU_T_ADD;
      default:      tlen = JBU_T_FETCH;
    endcase
    // Last clock state of the current machine cycle
    tlast = (s.tcnt == tlen - 3'h1);

    if (!tlast)
    begin
      next_s.tcnt = s.tcnt + 3'h1;
    end
    else
    begin
      case (s.state)
        JBU_ST_FETCH:
        begin
          next_s.pc     = pc_inc;
          next_s.opcode = i_mem_data;
          if (i_mem_data == JBU_OP_PREFIX_IX && !s.prefix)
          begin
            next_s.prefix = 1'b1;
            go = JBU_ST_FETCH;
          end
          else if (i_mem_data == JBU_OP_PTR_JUMP)
          begin
            // Pair is copied on the last state of the opcode fetch
            if (s.prefix)
            begin
              next_s.pc = ADDR_W'(i_first_index_pair);
            end
            else
            begin
              next_s.pc = ADDR_W'(i_pointer_pair);
            end
            next_s.taken = 1'b1;
            finish = 1'b1;
          end
          else if (!s.prefix && i_mem_data == JBU_OP_ABS_JUMP)
          begin
            go = JBU_ST_LO;
          end
          else if (op_abs_cond)
          begin
            go = JBU_ST_LO;
          end
          else if (op_rel)
          begin
            go = JBU_ST_DISP;
          end
          else
          begin
            // Not ours: the core runs it; flags are left to the core
            next_s.foreign     = 1'b1;
            next_s.foreign_op  = i_mem_data;
            next_s.foreign_pfx = s.prefix;
            finish = 1'b1;
          end
        end

        JBU_ST_LO:
        begin
          next_s.lo = i_mem_data;
          next_s.pc = pc_inc;
          go = JBU_ST_HI;
        end

        JBU_ST_HI:
        begin
          // Flags are judged on the last state of the high byte read
          if (s.opcode == JBU_OP_ABS_JUMP || cond_true)
          begin
            next_s.pc    = ADDR_W'({i_mem_data, s.lo});
            next_s.taken = 1'b1;
          end
          else
          begin
            next_s.pc = pc_inc;
          end
          finish = 1'b1;
        end

        JBU_ST_DISP:
        begin
          // Counter now points past both bytes
          next_s.pc   = pc_inc;
          next_s.disp = i_mem_data;
          // Condition is judged once the displacement is in
          if (s.opcode == JBU_OP_REL_ALWAYS || cond_true)
          begin
            go = JBU_ST_ADD;
          end
          else
          begin
            finish = 1'b1;
          end
        end

        JBU_ST_ADD:
        begin
          // Wraps at the top of the address space
          next_s.pc    = rel_target;
          next_s.taken = 1'b1;
          finish = 1'b1;
        end

        default:
        begin
          finish = 1'b1;
        end
      endcase

      next_s.tcnt = 3'h0;
      next_s.mcnt = s.mcnt + 3'h1;
      // End of instruction: publish counts and return to fetch
      if (finish)
      begin
        go = JBU_ST_FETCH;
        next_s.done   = 1'b1;
        next_s.prefix = 1'b0;
        next_s.last_m = s.mcnt + 3'h1;
        next_s.mcnt   = 3'h0;
      end
      next_s.state  = go;
      // The add cycle leaves the memory idle
      next_s.mem_rd = (go != JBU_ST_ADD);
      next_s.m1     = (go == JBU_ST_FETCH);
    end

    // Clock-state count of the current instruction
    if (tlast && finish)
    begin
      next_s.last_t = s.tsum + 5'h01;
      next_s.tsum   = 5'h00;
    end
    else
    begin
      next_s.tsum = s.tsum + 5'h01;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      s <= REGS_RESET;
    end
    else
    begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // No flag output exists: the jump group never writes flags.
  assign o_program_counter  = s.pc;
  assign o_mem_rd           = s.mem_rd;
  assign o_m1               = s.m1;
  assign o_instr_done       = s.done;
  assign o_branch_taken     = s.taken;
  assign o_last_mcycles     = s.last_m;
  assign o_last_tstates     = s.last_t;
  assign o_foreign_op       = s.foreign;
  assign o_foreign_opcode   = s.foreign_op;
  assign o_foreign_prefixed = s.foreign_pfx;

endmodule

// ---- jbu_pkg.sv ----
// Constants, codes and state encodings of the jump and branch unit.
// Assumes the core treats every clock edge as one clock state.
package jbu_pkg;

  // ----------------------------------------------------------------
  // Opcodes handled by the unit
  // ----------------------------------------------------------------
  localparam logic [7:0] JBU_OP_ABS_JUMP   = 8'hc3;
  localparam logic [7:0] JBU_OP_REL_ALWAYS = 8'h18;
  localparam logic [7:0] JBU_OP_REL_NZ     = 8'h20;
  localparam logic [7:0] JBU_OP_REL_Z      = 8'h28;
  localparam logic [7:0] JBU_OP_REL_NC     = 8'h30;
  localparam logic [7:0] JBU_OP_REL_C      = 8'h38;
  localparam logic [7:0] JBU_OP_PTR_JUMP   = 8'he9;
  localparam logic [7:0] JBU_OP_PREFIX_IX  = 8'hdd;
  // Conditional absolute jump: 11 ccc 010
  localparam logic [7:0] JBU_ABS_COND_MASK = 8'hc7;
  localparam logic [7:0] JBU_ABS_COND_PAT  = 8'hc2;

  // ----------------------------------------------------------------
  // Flag register bit positions
  // ----------------------------------------------------------------
  localparam int JBU_FLAG_SIGN   = 7;
  localparam int JBU_FLAG_ZERO   = 6;
  localparam int JBU_FLAG_PARITY = 2;
  localparam int JBU_FLAG_CARRY  = 0;

  // ----------------------------------------------------------------
  // Clock states per machine cycle
  // ----------------------------------------------------------------
  localparam logic [2:0] JBU_T_FETCH = 3'h4;
  localparam logic [2:0] JBU_T_READ  = 3'h3;
  localparam logic [2:0] JBU_T_ADD   = 3'h5;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] JBU_PC_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    JBU_ST_FETCH = 5'b00001,
    JBU_ST_LO    = 5'b00010,
    JBU_ST_HI    = 5'b00100,
    JBU_ST_DISP  = 5'b01000,
    JBU_ST_ADD   = 5'b10000
  } jbu_state_t;

endpackage

// ---- jbu_cond_eval.sv ----
// Evaluates a 3-bit condition field against the flag register.
// Assumes flags are stable while the field is evaluated.
`timescale 1ns/100ps
module jbu_cond_eval
(
  input  wire logic [2:0] i_condition_field,
  input  wire logic [7:0] i_flags,
  output logic            o_cond_true
);
  import jbu_pkg::*;

  always_comb
  begin
    case (i_condition_field)
      3'h0:    o_cond_true = !i_flags[JBU_FLAG_ZERO];
      3'h1:    o_cond_true = i_flags[JBU_FLAG_ZERO];
      3'h2:    o_cond_true = !i_flags[JBU_FLAG_CARRY];
      3'h3:    o_cond_true = i_flags[JBU_FLAG_CARRY];
      3'h4:    o_cond_true = !i_flags[JBU_FLAG_PARITY];
      3'h5:    o_cond_true = i_flags[JBU_FLAG_PARITY];
      3'h6:    o_cond_true = !i_flags[JBU_FLAG_SIGN];
      default: o_cond_true = i_flags[JBU_FLAG_SIGN];
    endcase
  end

endmodule

// ---- jbu_rel_target.sv ----
// Relative branch target: counter plus sign-extended displacement.
// Assumes the counter already points past both instruction bytes.
`timescale 1ns/100ps
module jbu_rel_target
#(
  parameter int ADDR_W = 16
)
(
  input  wire logic [ADDR_W-1:0] i_base,
  input  wire logic [7:0]        i_disp,
  output logic      [ADDR_W-1:0] o_target
);

  logic [ADDR_W-1:0] disp_ext;

  // Wraps modulo the address width
  assign disp_ext = {{(ADDR_W-8){i_disp[7]}}, i_disp};
  assign o_target = i_base + disp_ext;

endmodule

// ---- jbu_prog_mem.sv ----
// Program memory model for the jump and branch unit.
// Assumes the testbench loads the array before the unit fetches from it.
`timescale 1ns/100ps
module jbu_prog_mem
(
  input  wire logic        i_clk,
  input  wire logic [15:0] i_addr,
  input  wire logic        i_rd,
  output logic      [7:0]  o_data
);
  logic [7:0] mem [65536];
  logic [7:0] last = 8'h00;
  // Released bus toggles each clock: the inverse of the last byte read, then that byte again
  assign o_data = i_rd ? mem[i_addr] : ~last;
  always @(posedge i_clk)
  begin
    last <= o_data;
  end
  initial
  begin
    foreach (mem[a])
      mem[a] = 8'h00;
  end
endmodule

// ---- jbu_chk_chk.sv ----
// Timing and target checks of the jump and branch unit at its ports.
// Assumes flags and register pairs hold still through an instruction.
`timescale 1ns/100ps
module jbu_chk
#(
  parameter int ADDR_W = 16
)
(
  input wire logic              i_sys_clk,
  input wire logic              i_reset,
  input wire logic [7:0]        i_mem_data,
  input wire logic [7:0]        i_flags,
  input wire logic [15:0]       i_pointer_pair,
  input wire logic [15:0]       i_first_index_pair,
  input wire logic [ADDR_W-1:0] o_program_counter,
  input wire logic              o_mem_rd,
  input wire logic              o_m1,
  input wire logic              o_instr_done,
  input wire logic              o_branch_taken,
  input wire logic [2:0]        o_last_mcycles,
  input wire logic [4:0]        o_last_tstates
);
  function automatic logic cond_ok(input logic [2:0] cc, input logic [7:0] f);
    return cc[0] == (cc[2] ? (cc[1] ? f[7] : f[2]) : (cc[1] ? f[0] : f[6]));
  endfunction
  wire rel_c  = i_mem_data[7:5] == 3'h1 && i_mem_data[2:0] == 3'h0;
  wire rel_go = i_mem_data == 8'h18 || (rel_c && cond_ok({1'b0, i_mem_data[4:3]}, i_flags));
  wire abs_op = i_mem_data == 8'hc3 || (i_mem_data & 8'hc7) == 8'hc2;
  wire abs_go = i_mem_data == 8'hc3 || cond_ok(i_mem_data[5:3], i_flags);
  default clocking dc @(posedge i_sys_clk);
  endclocking
  default disable iff (i_reset);
  // ------------------------------------------------------------
  // Opcode seen on, and start of, the first fetch after an instruction ends
  // ------------------------------------------------------------
  abs_jump_a: assert property (
    o_instr_done ##3 (o_m1 && abs_op) |-> ##7 (o_instr_done && o_last_tstates == 5'h0a
    && o_last_mcycles == 3'h3 && o_branch_taken == $past(abs_go, 7)
    && o_program_counter == ($past(abs_go, 7) ? {$past(i_mem_data, 1), $past(i_mem_data, 4)}
    : $past(o_program_counter, 7) + 16'h0003)))
    else $error("absolute jump outcome wrong");
  operand_read_a: assert property (
    o_instr_done ##3 abs_op |-> ##1 (o_mem_rd && !o_m1)[*6] ##1 o_m1)
    else $error("operand reads wrong");
  rel_taken_a: assert property (
    o_instr_done ##3 rel_go |-> ##4 (!o_mem_rd)[*5] ##1 (o_instr_done && o_branch_taken
    && o_last_tstates == 5'h0c && o_last_mcycles == 3'h3 && o_program_counter ==
    $past(o_program_counter, 9) + 16'h0002 + {{8{$past(i_mem_data[7], 6)}}, $past(i_mem_data, 6)}))
    else $error("taken branch wrong");
  rel_skip_a: assert property (
    o_instr_done ##3 (rel_c && !rel_go) |-> ##4 (o_instr_done && !o_branch_taken
    && o_last_tstates == 5'h07 && o_last_mcycles == 3'h2
    && o_program_counter == $past(o_program_counter, 4) + 16'h0002))
    else $error("skipped branch wrong");
  ptr_jump_a: assert property (
    o_instr_done ##3 (i_mem_data == 8'he9) |-> ##1 (o_instr_done && o_last_mcycles == 3'h1
    && o_last_tstates == 5'h04 && o_program_counter == $past(i_pointer_pair)))
    else $error("pointer jump wrong");
  index_jump_a: assert property (
    o_instr_done ##3 (i_mem_data == 8'hdd) ##4 (i_mem_data == 8'he9) |-> ##1 (o_instr_done
    && o_last_mcycles == 3'h2 && o_last_tstates == 5'h08
    && o_program_counter == $past(i_first_index_pair)))
    else $error("index jump wrong");
  fetch_start_a: assert property (o_instr_done |-> o_m1 && o_mem_rd)
    else $error("fetch not started");
  fetch_hold_a: assert property (o_instr_done |=> $stable(o_program_counter)[*3])
    else $error("fetch address moved");
endmodule

// ---- jbu_jump_branch_unit_tb.sv ----
// Self-checking bench of the jump and branch unit.
// Assumes a zero-wait program memory model beside the unit.
`timescale 1ns/100ps
module jbu_jump_branch_unit_tb;
  import jbu_pkg::*;
  logic        i_sys_clk = 1'b0;
  logic        i_reset = 1'b1;
  logic [7:0]  i_flags = 8'h00;
  logic [15:0] i_pointer_pair = 16'h0000;
  logic [15:0] i_first_index_pair = 16'h0000;
  logic [7:0]  i_mem_data, o_foreign_opcode;
  logic [15:0] o_program_counter;
  logic        o_mem_rd, o_m1, o_instr_done, o_branch_taken, o_foreign_op, o_foreign_prefixed;
  logic [2:0]  o_last_mcycles;
  logic [4:0]  o_last_tstates;
  int          err_total = 0;
  int          checks_done = 0;
  always #25 i_sys_clk = ~i_sys_clk;
  jbu_jump_branch_unit dut (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_mem_data(i_mem_data),
    .i_flags(i_flags), .i_pointer_pair(i_pointer_pair), .i_first_index_pair(i_first_index_pair),
    .o_program_counter(o_program_counter), .o_mem_rd(o_mem_rd), .o_m1(o_m1),
    .o_instr_done(o_instr_done), .o_branch_taken(o_branch_taken),
    .o_last_mcycles(o_last_mcycles), .o_last_tstates(o_last_tstates),
    .o_foreign_op(o_foreign_op), .o_foreign_opcode(o_foreign_opcode),
    .o_foreign_prefixed(o_foreign_prefixed));
  jbu_prog_mem prog_i (.i_clk(i_sys_clk), .i_addr(o_program_counter), .i_rd(o_mem_rd),
    .o_data(i_mem_data));
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic restart();
    @(posedge i_sys_clk);
    i_reset <= 1'b1;
    @(posedge i_sys_clk);
    i_reset <= 1'b0;
  endtask
  // Waits for the end of the next instruction and judges it
  task automatic step(input logic [15:0] pc, input logic tk, input logic [2:0] m,
    input logic [4:0] t);
    int n;
    n = 0;
    do
    begin
      @(negedge i_sys_clk);
      n++;
    end
    while (o_instr_done !== 1'b1 && n < 40);
    cmp("done", 16'h0001, {15'h0000, o_instr_done});
    cmp("counter", pc, o_program_counter);
    cmp("taken", {15'h0000, tk}, {15'h0000, o_branch_taken});
    cmp("mcycles", {13'h0000, m}, {13'h0000, o_last_mcycles});
    cmp("tstates", {11'h000, t}, {11'h000, o_last_tstates});
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_abs_chain();
    prog_i.mem[1] = JBU_OP_ABS_JUMP;
    prog_i.mem[2] = 8'h34;
    prog_i.mem[3] = 8'h12;
    prog_i.mem[16'h1234] = JBU_OP_PTR_JUMP;
    prog_i.mem[16'hbeef] = JBU_OP_PREFIX_IX;
    prog_i.mem[16'hbef0] = JBU_OP_PTR_JUMP;
    prog_i.mem[16'h5a5a] = JBU_OP_PREFIX_IX;
    prog_i.mem[16'h5a5b] = JBU_OP_ABS_JUMP;
    i_pointer_pair <= 16'hbeef;
    i_first_index_pair <= 16'h5a5a;
    restart();
    step(16'h0001, 1'b0, 3'h1, 5'h04);
    step(16'h1234, 1'b1, 3'h3, 5'h0a);
    cmp("foreign", 16'h0000, {15'h0000, o_foreign_op});
    step(16'hbeef, 1'b1, 3'h1, 5'h04);
    step(16'h5a5a, 1'b1, 3'h2, 5'h08);
    step(16'h5a5c, 1'b0, 3'h2, 5'h08);
    cmp("foreign", 16'h0001, {15'h0000, o_foreign_op});
    cmp("foreign opcode", 16'h00c3, {8'h00, o_foreign_opcode});
    cmp("prefixed", 16'h0001, {15'h0000, o_foreign_prefixed});
    $display("test abs chain ended");
  endtask
  // Only the flag that the field selects is set or cleared against the rest
  task automatic t_abs_cond();
    logic [2:0] cc;
    logic [7:0] sel;
    logic       go;
    for (int i = 0; i < 16; i++)
    begin
      cc = i[3:1];
      sel = 8'h01 << (cc[2] ? (cc[1] ? 7 : 2) : (cc[1] ? 0 : 6));
      go = cc[0] == i[0];
      prog_i.mem[1] = {2'b11, cc, 3'b010};
      prog_i.mem[2] = 8'h21;
      prog_i.mem[3] = 8'h43;
      @(posedge i_sys_clk);
      i_flags <= i[0] ? sel : ~sel;
      restart();
      step(16'h0001, 1'b0, 3'h1, 5'h04);
      step(go ? 16'h4321 : 16'h0004, go, 3'h3, 5'h0a);
    end
    $display("test abs cond ended");
  endtask
  task automatic t_rel();
    logic [7:0]  op, d;
    logic        go;
    logic [15:0] tgt;
    logic [2:0]  m;
    logic [4:0]  t;
    for (int i = 0; i < 10; i++)
    begin
      op = (i < 2) ? 8'h18 : {3'b001, 2'(i / 2 - 1), 3'b000};
      d = i[1] ? 8'h80 : 8'h7f;
      go = i < 2 || op[3] == i[0];
      tgt = go ? 16'h0003 + {{8{d[7]}}, d} : 16'h0003;
      m = go ? 3'h3 : 3'h2;
      t = go ? 5'h0c : 5'h07;
      prog_i.mem[1] = op;
      prog_i.mem[2] = d;
      @(posedge i_sys_clk);
      i_flags <= i[0] ? 8'h41 : 8'hbe;
      restart();
      step(16'h0001, 1'b0, 3'h1, 5'h04);
      step(tgt, go, m, t);
    end
    $display("test rel ended");
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge i_sys_clk);
    t_abs_chain();
    t_abs_cond();
    t_rel();
    print_verdict();
  end
  initial
  begin
    #300000;
    err_total++;
    print_verdict();
  end
endmodule
bind jbu_jump_branch_unit jbu_chk #(.ADDR_W(ADDR_W)) chk_i (.i_sys_clk(i_sys_clk),
  .i_reset(i_reset), .i_mem_data(i_mem_data), .i_flags(i_flags),
  .i_pointer_pair(i_pointer_pair), .i_first_index_pair(i_first_index_pair),
  .o_program_counter(o_program_counter), .o_mem_rd(o_mem_rd), .o_m1(o_m1),
  .o_instr_done(o_instr_done), .o_branch_taken(o_branch_taken),
  .o_last_mcycles(o_last_mcycles), .o_last_tstates(o_last_tstates));
